// ### shared/tmc_defines.svh
// Register offsets, field positions, codes and reset values of the timer
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TMC_OFS_CTRL        12'h000
`define TMC_OFS_GATE        12'h004
`define TMC_OFS_COUNT       12'h008

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define TMC_CTRL_SRC_HI     7
`define TMC_CTRL_SRC_LO     6
`define TMC_CTRL_PS_HI      5
`define TMC_CTRL_PS_LO      4
`define TMC_CTRL_OSC_EN     3
`define TMC_CTRL_SYNC_DIS   2
`define TMC_CTRL_UNUSED     1
`define TMC_CTRL_RUN        0
`define TMC_CTRL_WMASK      8'hFD
`define TMC_CTRL_RESET      8'h00

// ----------------------------------------------------------------
// Gate control register fields
// ----------------------------------------------------------------
`define TMC_GATE_EN         7
`define TMC_GATE_POL        6
`define TMC_GATE_TOGGLE     5
`define TMC_GATE_SPM        4
`define TMC_GATE_GO         3
`define TMC_GATE_VAL        2
`define TMC_GATE_RESET      8'h00

// ----------------------------------------------------------------
// Clock source and prescale codes
// ----------------------------------------------------------------
`define TMC_SRC_INSTR       2'h0
`define TMC_SRC_SYSTEM      2'h1
`define TMC_SRC_PIN         2'h2
`define TMC_SRC_CAPSENSE    2'h3
`define TMC_PS_DIV1         2'h0
`define TMC_PS_DIV2         2'h1
`define TMC_PS_DIV4         2'h2
`define TMC_PS_DIV8         2'h3

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define TMC_INSTR_DIV_LAST  2'h3
`define TMC_COUNT_MAX       16'hFFFF
`define TMC_COUNT_RESET     16'h0000

`endif

// ### shared/tmc_pkg.sv
// Types shared by the timer control block and its bench
package tmc_pkg;

	// ------------------------------------------------------------
	// Register layouts
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] clock_source_select;
		logic [1:0] prescale_select;
		logic       dedicated_osc_enable;
		logic       external_sync_disable;
		logic       unused;
		logic       timer_run_enable;
	} tmc_ctrl_t;

	typedef struct packed {
		logic       gate_enable;
		logic       gate_polarity;
		logic       gate_toggle_mode;
		logic       gate_single_pulse_mode;
		logic       single_pulse_go_done;
		logic       gate_current_level;
		logic [1:0] gate_source_select;
	} tmc_gate_t;

	// ------------------------------------------------------------
	// APB carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} tmc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} tmc_apb_rsp_t;

	// ------------------------------------------------------------
	// Whole state of the timer
	// ------------------------------------------------------------
	typedef struct packed {
		tmc_ctrl_t   ctrl;
		tmc_gate_t   gate;
		logic [15:0] count;
		logic [2:0]  presc;
		logic [1:0]  instr_div;
		logic        sync_a;
		logic        sync_b;
		logic        src_prev;
		logic        gate_prev;
		logic        toggle;
		logic        pulse_armed;
		logic        overflow;
		logic        xtal_out;
		logic [31:0] prdata;
	} tmc_state_t;

endpackage

// ### core/tmc_timer.sv
// Sixteen-bit timer with clock source, prescale, sync and gate control
//
// Overview of operation
// - Source 00 instruction clock, 01 system clock
// - Source 10: pin edges, or crystal
// - Source 11: capacitive sensing oscillator
// - Prescale 1:1, 1:2, 1:4, 1:8
// - Oscillator enable bit drives crystal circuit
// - External source synchronised unless sync disabled
// - Sync bit ignored for internal sources
// - Run bit counts; clearing it clears toggle
// - Control bit 1 reads zero, ignores writes
// - Power-on reset clears all control bits
// - Go/done cleared on trailing gate pulse edge
// - Count rolls over from FFFF to 0000
// - Gate level readable even when gating off
`timescale 1ns/1ps
`include "tmc_defines.svh"

module tmc_timer
(
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire tmc_pkg::tmc_apb_req_t apb_req,
	output      tmc_pkg::tmc_apb_rsp_t apb_rsp,
	input  wire logic                  external_clock_pin,
	input  wire logic                  crystal_in_pin,
	input  wire logic                  capacitive_sense_osc,
	input  wire logic [3:0]            gate_source_in,
	output      logic                  crystal_out_pin,
	output      logic                  crystal_out_oe,
	output      logic                  dedicated_osc_enable,
	output      logic [15:0]           timer_count,
	output      logic                  timer_overflow,
	output      logic                  gate_current_level
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	tmc_pkg::tmc_state_t q;
	tmc_pkg::tmc_state_t d;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic        bus_setup;
	logic        bus_access;
	logic        hit_ctrl;
	logic        hit_gate;
	logic        hit_count;
	logic        hit_any;
	logic        wr_ctrl;
	logic        wr_gate;
	logic        wr_count;
	logic [31:0] rd_mux;
	logic        gate_value;

	assign bus_setup  = apb_req.psel & ~apb_req.penable;
	assign bus_access = apb_req.psel & apb_req.penable;
	assign hit_ctrl   = apb_req.paddr == `TMC_OFS_CTRL;
	assign hit_gate   = apb_req.paddr == `TMC_OFS_GATE;
	assign hit_count  = apb_req.paddr == `TMC_OFS_COUNT;
	assign hit_any    = hit_ctrl | hit_gate | hit_count;
	assign wr_ctrl    = bus_access & apb_req.pwrite & hit_ctrl;
	assign wr_gate    = bus_access & apb_req.pwrite & hit_gate;
	assign wr_count   = bus_access & apb_req.pwrite & hit_count;

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		if (hit_ctrl)
		begin
			rd_mux[7:0] = q.ctrl;
			rd_mux[`TMC_CTRL_UNUSED] = 1'b0;
		end
		else if (hit_gate)
		begin
			rd_mux[7:0] = q.gate;
			rd_mux[`TMC_GATE_VAL] = gate_value;
		end
		else if (hit_count)
		begin
			rd_mux[15:0] = q.count;
		end
	end

	// ------------------------------------------------------------
	// Clock source selection
	// ------------------------------------------------------------
	logic src_external;
	logic ext_level;
	logic ext_sampled;
	logic ext_edge;
	logic instr_tick;
	logic src_tick;

	assign src_external = q.ctrl.clock_source_select[1];
	assign instr_tick   = q.instr_div == `TMC_INSTR_DIV_LAST;

	always_comb
	begin
		if (q.ctrl.clock_source_select == `TMC_SRC_CAPSENSE)
		begin
			ext_level = capacitive_sense_osc;
		end
		else if (q.ctrl.dedicated_osc_enable)
		begin
			ext_level = crystal_in_pin;
		end
		else
		begin
			ext_level = external_clock_pin;
		end
	end

	// Sync path adds two flops of latency; bypass takes the level directly
	assign ext_sampled = q.ctrl.external_sync_disable ? ext_level
		: q.sync_b;
	assign ext_edge    = ext_sampled & ~q.src_prev;

	always_comb
	begin
		unique case (q.ctrl.clock_source_select)
			`TMC_SRC_INSTR:
			begin
				src_tick = instr_tick;
			end
			`TMC_SRC_SYSTEM:
			begin
				src_tick = 1'b1;
			end
			default:
			begin
				src_tick = ext_edge;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	logic [2:0] presc_last;
	logic       presc_tick;

	always_comb
	begin
		unique case (q.ctrl.prescale_select)
			`TMC_PS_DIV1: presc_last = 3'h0;
			`TMC_PS_DIV2: presc_last = 3'h1;
			`TMC_PS_DIV4: presc_last = 3'h3;
			`TMC_PS_DIV8: presc_last = 3'h7;
		endcase
	end

	assign presc_tick = src_tick & (q.presc >= presc_last);

	// ------------------------------------------------------------
	// Gate path
	// ------------------------------------------------------------
	logic gate_raw;
	logic gate_polar;
	logic gate_rise;
	logic gate_fall;
	logic gate_open;
	logic count_tick;

	assign gate_raw   = gate_source_in[q.gate.gate_source_select];
	assign gate_polar = q.gate.gate_polarity ? gate_raw : ~gate_raw;
	assign gate_rise  = gate_polar & ~q.gate_prev;
	assign gate_value = q.gate.gate_toggle_mode ? q.toggle : gate_polar;
	assign gate_fall  = ~gate_value & q.gate.gate_current_level;

	// Single-pulse mode passes only the armed pulse
	assign gate_open = q.gate.gate_single_pulse_mode
		? (gate_value & q.pulse_armed) : gate_value;

	assign count_tick = presc_tick & q.ctrl.timer_run_enable
		& (~q.gate.gate_enable | gate_open);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.overflow = 1'b0;

		// Bus read data captured in the setup phase
		if (bus_setup)
		begin
			d.prdata = rd_mux;
		end

		// Instruction clock divider runs free
		d.instr_div = q.instr_div + 2'h1;

		// External clock synchroniser and edge detector
		d.sync_a   = ext_level;
		d.sync_b   = q.sync_a;
		d.src_prev = src_external ? ext_sampled : 1'b0;

		// Prescaler counts selected source edges
		if (src_tick)
		begin
			d.presc = presc_tick ? 3'h0 : q.presc + 3'h1;
		end

		// Crystal driver inverts the input while enabled
		d.xtal_out = q.ctrl.dedicated_osc_enable
			& ~crystal_in_pin;

		// Gate toggle flip-flop
		d.gate_prev = gate_polar;
		if (!q.gate.gate_toggle_mode || !q.ctrl.timer_run_enable)
		begin
			d.toggle = 1'b0;
		end
		else if (gate_rise)
		begin
			d.toggle = ~q.toggle;
		end

		// Gate level kept current whether or not gating is on
		d.gate.gate_current_level = gate_value;

		// Single-pulse capture
		if (q.gate.single_pulse_go_done && gate_value
			&& !q.gate.gate_current_level)
		begin
			d.pulse_armed = 1'b1;
		end
		if (q.pulse_armed && gate_fall)
		begin
			d.pulse_armed = 1'b0;
			d.gate.single_pulse_go_done = 1'b0;
		end
		if (!q.gate.gate_single_pulse_mode)
		begin
			d.pulse_armed = 1'b0;
		end

		// Counter with rollover
		if (count_tick)
		begin
			d.count = q.count + 16'h0001;
			d.overflow = q.count == `TMC_COUNT_MAX;
		end

		// Register writes; a write to the count wins over a tick
		if (wr_ctrl)
		begin
			d.ctrl = apb_req.pwdata[7:0] & `TMC_CTRL_WMASK;
			if (!apb_req.pwdata[`TMC_CTRL_RUN])
			begin
				d.toggle = 1'b0;
			end
		end
		if (wr_gate)
		begin
			d.gate.gate_enable = apb_req.pwdata[`TMC_GATE_EN];
			d.gate.gate_polarity = apb_req.pwdata[`TMC_GATE_POL];
			d.gate.gate_toggle_mode = apb_req.pwdata[`TMC_GATE_TOGGLE];
			d.gate.gate_single_pulse_mode = apb_req.pwdata[`TMC_GATE_SPM];
			d.gate.gate_source_select = apb_req.pwdata[1:0];
			// Software set beats a same-cycle hardware clear
			if (apb_req.pwdata[`TMC_GATE_GO])
			begin
				d.gate.single_pulse_go_done = 1'b1;
			end
			else
			begin
				d.gate.single_pulse_go_done = 1'b0;
			end
		end
		if (wr_count)
		begin
			d.count = apb_req.pwdata[15:0];
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.ctrl <= `TMC_CTRL_RESET;
			q.gate <= `TMC_GATE_RESET;
			q.count <= `TMC_COUNT_RESET;
		end
		else
		begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.prdata  = q.prdata;
	assign apb_rsp.pslverr = bus_access & ~hit_any;

	assign crystal_out_pin      = q.xtal_out;
	assign crystal_out_oe       = q.ctrl.dedicated_osc_enable;
	assign dedicated_osc_enable = q.ctrl.dedicated_osc_enable;
	assign timer_count          = q.count;
	assign timer_overflow       = q.overflow;
	assign gate_current_level   = q.gate.gate_current_level;

endmodule

// ### test/tmc_timer_assertions.sv
// Assertions on the ports of the timer control block
`timescale 1ns/1ps

module tmc_timer_assertions
(
	input wire logic                  core_clk,
	input wire logic                  rst_b,
	input wire tmc_pkg::tmc_apb_req_t apb_req,
	input wire tmc_pkg::tmc_apb_rsp_t apb_rsp,
	input wire logic                  crystal_in_pin,
	input wire logic                  crystal_out_pin,
	input wire logic                  crystal_out_oe,
	input wire logic                  dedicated_osc_enable,
	input wire logic [15:0]           timer_count,
	input wire logic                  timer_overflow
);
	// ----
	// Shadow of written control bits
	// ----
	logic [7:0] ctrl_q;
	logic       gen_q;
	logic       acc;
	logic       wr;
	logic       base;
	logic       ins1;
	logic       sys1;
	logic       sys8;

	assign acc  = apb_req.psel && apb_req.penable;
	assign wr   = acc && apb_req.pwrite;
	assign base = ctrl_q[0] && !gen_q && !(wr && apb_req.paddr == 12'h008);
	assign ins1 = base && ctrl_q[7:4] == 4'h0;
	assign sys1 = base && ctrl_q[7:4] == 4'h4;
	assign sys8 = base && ctrl_q[7:4] == 4'h7;

	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			ctrl_q <= 8'h00;
			gen_q  <= 1'b0;
		end
		else if (wr && apb_req.paddr == 12'h000)
			ctrl_q <= apb_req.pwdata[7:0] & 8'hFD;
		else if (wr && apb_req.paddr == 12'h004)
			gen_q <= apb_req.pwdata[7];
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	chk_osc_pin_enable: assert property (crystal_out_oe == dedicated_osc_enable)
		else $error("crystal pin enable differs from oscillator bit");
	chk_xtal_drive: assert property (dedicated_osc_enable == $past(dedicated_osc_enable)
		|-> crystal_out_pin == (dedicated_osc_enable && !$past(crystal_in_pin)))
		else $error("crystal output wrong");
	chk_stop_hold: assert property (!ctrl_q[0] && !(wr && apb_req.paddr == 12'h008)
		|=> $stable(timer_count))
		else $error("count moved while stopped");
	chk_sys_rate: assert property (sys1 [*3] |=> timer_count == $past(timer_count) + 16'h1)
		else $error("system clock count rate wrong");
	chk_instr_rate: assert property (ins1 [*8] |-> timer_count - $past(timer_count, 4) == 16'h1)
		else $error("instruction clock count rate wrong");
	chk_div8_rate: assert property (sys8 [*8] ##1 sys8 [*8]
		|-> timer_count - $past(timer_count, 8) == 16'h1)
		else $error("divide by eight rate wrong");
	chk_ovf_pulse: assert property (timer_overflow |-> !$past(timer_overflow)
		&& ($past(timer_count) == 16'hFFFF || $past(timer_count, 2) == 16'hFFFF))
		else $error("overflow pulse without rollover");
	chk_ctrl_read: assert property (acc && !apb_req.pwrite && apb_req.paddr == 12'h000
		|-> apb_rsp.prdata[7:0] == ctrl_q)
		else $error("control read value wrong");
	chk_slverr_map: assert property (acc |-> apb_rsp.pslverr
		== !(apb_req.paddr inside {12'h000, 12'h004, 12'h008}))
		else $error("error response wrong");
endmodule

bind tmc_timer tmc_timer_assertions i_tmc_timer_assertions
(
	.core_clk,
	.rst_b,
	.apb_req,
	.apb_rsp,
	.crystal_in_pin,
	.crystal_out_pin,
	.crystal_out_oe,
	.dedicated_osc_enable,
	.timer_count,
	.timer_overflow
);

// ### test/test_tmc_timer.sv
// Self-checking bench of the timer control block
`timescale 1ns/1ps

module test_tmc_timer;
	logic                  core_clk   = 1'b0;
	logic                  rst_b      = 1'b0;
	tmc_pkg::tmc_apb_req_t req        = '0;
	tmc_pkg::tmc_apb_rsp_t rsp;
	logic [3:0]            ph         = 4'h0;
	logic [3:0]            gsrc       = 4'h0;
	logic [15:0]           cnt;
	logic                  ovf;
	logic                  lvl;
	logic                  oscen;
	logic [31:0]           seed       = 32'h097E;
	logic [31:0]           v;
	logic [31:0]           rd;
	logic                  er;
	int                    fail_count = 0;
	int                    n_checks   = 0;

	tmc_timer i_tmc_timer
	(
		.core_clk             (core_clk),
		.rst_b                (rst_b),
		.apb_req              (req),
		.apb_rsp              (rsp),
		.external_clock_pin   (ph[1]),
		.crystal_in_pin       (ph[2]),
		.capacitive_sense_osc (ph[3]),
		.gate_source_in       (gsrc),
		.crystal_out_pin      (),
		.crystal_out_oe       (),
		.dedicated_osc_enable (oscen),
		.timer_count          (cnt),
		.timer_overflow       (ovf),
		.gate_current_level   (lvl)
	);

	// Pin, crystal and sense clocks of 4, 8, 16 cycles
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) ph <= ph + 4'h1;

	function logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge core_clk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 50);
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task run(input logic [7:0] c, input logic [15:0] s);
		apb(1'b1, 12'h008, {16'h0000, s});
		apb(1'b1, 12'h000, {24'h000000, c});
	endtask

	// Count advance and overflow pulses over 64 cycles
	task meas(input logic [15:0] e);
		logic [15:0] c0;
		logic [15:0] d;
		int          no;
		no = 0;
		repeat (16) @(posedge core_clk);
		c0 = cnt;
		repeat (64)
		begin
			@(posedge core_clk);
			no += 32'(ovf);
		end
		d = cnt - c0;
		chk({16'h0000, d}, {16'h0000, e});
		chk(32'(no), 32'(({1'b0, c0} + e) > 17'h0FFFF));
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		#400000;
		fail_count++;
		finish_test();
	end

	initial
	begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		repeat (8)
		begin
			v = xs() & 32'h000000FE;
			apb(1'b1, 12'h000, v);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd & 32'h000000FF, v & 32'h000000FD);
			chk(32'(oscen), 32'(v[3]));
		end
		apb(1'b1, 12'h010, 32'h000000FF);
		chk(32'(er), 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd & 32'h000000FF, v & 32'h000000FD);
		apb(1'b0, 12'h00C, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		$display("test registers done");
		for (int i = 0; i < 8; i++)
		begin
			v = xs();
			run({1'b0, i[2], i[1:0], 1'b0, v[0], 2'b01}, 16'h0000);
			meas(16'h0040 >> ((i & 3) + (i[2] ? 0 : 2)));
		end
		run(8'h40, 16'h0000);
		meas(16'h0000);
		run(8'h81, 16'h0000);
		meas(16'h0010);
		run(8'h85, 16'h0000);
		meas(16'h0010);
		run(8'h89, 16'h0000);
		meas(16'h0008);
		run(8'hC1, 16'h0000);
		meas(16'h0004);
		run(8'h41, 16'hFFC0);
		meas(16'h0040);
		$display("test clocking done");
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, 12'h004, 32'h40 | 32'(s));
			gsrc <= 4'h1 << s;
			repeat (4) @(posedge core_clk);
			chk(32'(lvl), 32'h1);
			gsrc <= ~(4'h1 << s);
			repeat (4) @(posedge core_clk);
			chk(32'(lvl), 32'h0);
		end
		apb(1'b1, 12'h004, 32'h000000C0);
		gsrc <= 4'h0;
		run(8'h41, 16'h0000);
		meas(16'h0000);
		gsrc <= 4'h1;
		meas(16'h0040);
		gsrc <= 4'h0;
		apb(1'b1, 12'h004, 32'h000000D8);
		run(8'h41, 16'h0000);
		gsrc <= 4'h1;
		repeat (10) @(posedge core_clk);
		gsrc <= 4'h0;
		repeat (4) @(posedge core_clk);
		apb(1'b0, 12'h004, 32'h0);
		chk(32'(rd[3]), 32'h0);
		v = 32'(cnt);
		chk(32'(v != 0), 32'h1);
		gsrc <= 4'h1;
		repeat (10) @(posedge core_clk);
		gsrc <= 4'h0;
		repeat (4) @(posedge core_clk);
		chk(32'(cnt), v);
		$display("test gate done");
		finish_test();
	end
endmodule
